// File: bench/control_side_model.sv
// Model of the controlling side: the shutdown dry contact and the current-loop source.
`timescale 1ns/10ps
`default_nettype none
module control_side_model (
   input wire logic clk,
   input wire logic open_req,
   input wire logic [15:0] loop_req_ua,
   output logic contact_closed,
   output logic [15:0] loop_ua
);
   logic closed_q = 1'b0;
   logic [15:0] loop_q = 16'h2EE0;
   // The contact and the loop current change only after a clock edge, like a relay and a source.
   always @(posedge clk) begin
      closed_q <= !open_req;
      loop_q <= loop_req_ua;
   end
   assign contact_closed = closed_q;
   assign loop_ua = loop_q;
endmodule : control_side_model
`default_nettype wire

// File: bench/tb_top.sv
// Self-checking testbench of the valve demand and mode selector.
`timescale 1ns/10ps
`default_nettype none
`include "valve_mode_defines.svh"
module tb_top;
   import valve_mode_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic open_req = 1'b1;
   logic [15:0] loop_req_ua = 16'h2EE0;
   logic shutdown_contact_closed;
   logic [15:0] loop_current_ua;
   logic [15:0] sensor_a_pos = 16'h7EF4, sensor_b_pos = 16'h7EF4;
   op_mode_t mode;
   demand_src_t demand_src;
   logic [15:0] position_setpoint, loop_output_ua, merged_position;
   logic position_control_en, current_close_en, pwm_close_en, status_contact_closed;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   logic [31:0] rd;
   logic [1:0] rr;
   logic [15:0] merge_exp [3] = '{16'h4E20, 16'h2710, 16'h3A98};

   control_side_model u_far (.clk, .open_req, .loop_req_ua, .contact_closed(shutdown_contact_closed),
      .loop_ua(loop_current_ua));
   valve_demand_mode_selector u_dut (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .shutdown_contact_closed, .loop_current_ua, .sensor_a_pos,
      .sensor_b_pos, .mode, .demand_src, .position_setpoint, .position_control_en,
      .current_close_en, .pwm_close_en, .loop_output_ua, .status_contact_closed, .merged_position);

   always #5 clk = ~clk;

   task automatic finish_test;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
      logic aw_hs, w_hs, aw_done, w_done, b_hs;
      aw_done = 1'b0;
      w_done = 1'b0;
      b_hs = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(negedge clk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         @(posedge clk);
         if (aw_hs) begin
            s_axi_awvalid <= 1'b0;
            aw_done = 1'b1;
         end
         if (w_hs) begin
            s_axi_wvalid <= 1'b0;
            w_done = 1'b1;
         end
      end
      while (!b_hs) begin
         @(negedge clk);
         b_hs = s_axi_bvalid;
         rr = s_axi_bresp;
         @(posedge clk);
      end
      s_axi_bready <= 1'b0;
   endtask : axi_write

   task automatic axi_read(input logic [11:0] a);
      logic r_hs;
      r_hs = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!r_hs) begin
         @(negedge clk);
         if (s_axi_arvalid && s_axi_arready) begin
            @(posedge clk);
            s_axi_arvalid <= 1'b0;
         end else begin
            r_hs = s_axi_rvalid;
            rd = s_axi_rdata;
            rr = s_axi_rresp;
            @(posedge clk);
         end
      end
      s_axi_rready <= 1'b0;
   endtask : axi_read

   task automatic settle;
      repeat (4) @(posedge clk);
      @(negedge clk);
   endtask : settle

   task automatic expect_state(input op_mode_t m, input logic [15:0] sp, input logic [15:0] ou,
      input logic sc);
      settle();
      chk("mode", mode, m);
      chk("setpoint", position_setpoint, sp);
      chk("output current", loop_output_ua, ou);
      chk("status contact", status_contact_closed, sc);
   endtask : expect_state

   task automatic reset_diag;
      axi_write(`REG_CTRL, 32'h0000_0002);
      axi_write(`REG_CTRL, 32'h0000_0000);
   endtask : reset_diag

   initial begin
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      expect_state(MODE_SHUTDOWN, 16'h09C4, 16'h0000, 1'b0);
      axi_read(`REG_CFG);
      chk("cfg reset", rd, `CFG_RESET);
      axi_read(`REG_DEMAND);
      chk("demand reset", rd, 32'h0000_09C4);
      axi_read(12'h100);
      chk("unmapped resp", rr, 2'b10);
      chk("unmapped data", rd, 32'h0);
      $display("test reset done");
      axi_write(`REG_DEMAND, 32'h0000_9C40);
      chk("write resp", rr, 2'b00);
      @(posedge clk);
      open_req <= 1'b0;
      expect_state(MODE_RUNNING, 16'h9C40, 16'h2EE0, 1'b1);
      chk("source", demand_src, SRC_FIELDBUS);
      chk("position control", position_control_en, 1'b1);
      axi_read(`REG_STATUS);
      chk("status reg", rd, 32'h0000_0020);
      axi_read(`REG_OUTPUT);
      chk("output reg", rd, 32'h0000_2EE0);
      @(posedge clk);
      sensor_a_pos <= 16'h09C4;
      sensor_b_pos <= 16'h09C4;
      expect_state(MODE_RUNNING, 16'h9C40, 16'h0FA0, 1'b1);
      @(posedge clk);
      sensor_a_pos <= 16'hF424;
      sensor_b_pos <= 16'hF424;
      expect_state(MODE_RUNNING, 16'h9C40, 16'h4E20, 1'b1);
      $display("test running done");
      axi_write(`REG_CFG, 32'h0002_0001);
      axi_write(`REG_CTRL, 32'h0000_0008);
      axi_write(`REG_FAULTS, 32'h0000_0002);
      @(posedge clk);
      open_req <= 1'b1;
      expect_state(MODE_SHUTDOWN, 16'h09C4, 16'h0000, 1'b0);
      chk("position control", position_control_en, 1'b1);
      reset_diag();
      axi_write(`REG_CTRL, 32'h0000_0008);
      @(posedge clk);
      open_req <= 1'b0;
      expect_state(MODE_RUNNING, 16'h7EF4, 16'h4E20, 1'b1);
      chk("source", demand_src, SRC_LOOP);
      axi_read(`REG_LOOP);
      chk("loop demand reg", rd, 32'h0000_7EF4);
      @(posedge clk);
      loop_req_ua <= 16'h4E20;
      expect_state(MODE_RUNNING, 16'hF424, 16'h4E20, 1'b1);
      axi_write(`REG_CTRL, 32'h0000_0000);
      expect_state(MODE_RUNNING, 16'h9C40, 16'h4E20, 1'b1);
      axi_write(`REG_FAULTS, 32'h0000_0001);
      expect_state(MODE_RUNNING, 16'hF424, 16'h4E20, 1'b1);
      chk("source", demand_src, SRC_LOOP);
      reset_diag();
      expect_state(MODE_RUNNING, 16'h9C40, 16'h4E20, 1'b1);
      $display("test source selection done");
      @(posedge clk);
      loop_req_ua <= 16'h03E8;
      expect_state(MODE_SHUTDOWN, 16'h09C4, 16'h0000, 1'b0);
      axi_read(`REG_FAULTS);
      chk("loop fault flag", rd, 32'h0000_0010);
      @(posedge clk);
      loop_req_ua <= 16'h59D8;
      reset_diag();
      expect_state(MODE_SHUTDOWN, 16'h09C4, 16'h0000, 1'b0);
      @(posedge clk);
      loop_req_ua <= 16'h2EE0;
      reset_diag();
      expect_state(MODE_RUNNING, 16'h9C40, 16'h4E20, 1'b1);
      $display("test loop fault done");
      @(posedge clk);
      sensor_a_pos <= 16'h2710;
      sensor_b_pos <= 16'h4E20;
      settle();
      chk("merged", merged_position, 16'h3A98);
      axi_read(`REG_SENSORS);
      chk("merged reg", rd, 32'h0000_3A98);
      axi_write(`REG_FAULTS, 32'h0000_0004);
      for (int c = 0; c < 3; c++) begin
         axi_write(`REG_CFG, {c[15:0], 16'h0001});
         settle();
         chk("merged", merged_position, merge_exp[c]);
      end
      reset_diag();
      axi_write(`REG_FAULTS, 32'h0000_0008);
      axi_write(`REG_CFG, 32'h0001_0001);
      settle();
      chk("merged", merged_position, 16'h2710);
      reset_diag();
      $display("test feedback merge done");
      axi_write(`REG_FAULTS, 32'h0000_0020);
      expect_state(MODE_SHUTDOWN_POSITION, 16'h09C4, 16'h0000, 1'b0);
      chk("position control", position_control_en, 1'b0);
      chk("current close", current_close_en, 1'b1);
      axi_write(`REG_FAULTS, 32'h0000_0040);
      expect_state(MODE_SHUTDOWN_SYSTEM, 16'h09C4, 16'h0000, 1'b0);
      chk("pwm close", pwm_close_en, 1'b1);
      reset_diag();
      expect_state(MODE_RUNNING, 16'h9C40, 16'h1CA5, 1'b1);
      $display("test mode priority done");
      finish_test();
   end
endmodule : tb_top
`default_nettype wire

// File: core/valve_demand_mode_selector.sv
// Demand source selection, operating mode control and feedback merge of a valve driver.
// Behaviour
// - Loop input 4 to 20 mA maps linearly to 0 to 100 percent demand.
// - Loop input below 2 mA or above 22 mA forces shutdown and zero output.
// - In normal operation output current follows position linearly, 4 to 20 mA.
// - Any shutdown condition sets the position output current to zero.
// - Open shutdown contact holds shutdown: zero demand, zero output, status open.
// - Closing the shutdown contact resets and resumes with the selected demand.
// - Status contact opens whenever shut down by input or diagnostic.
// - Status contact is open after power-up, closed only in normal operation.
// - Running mode controls position, closes status, output tracks measured position.
// - Plain shutdown keeps position control at zero setpoint, zero output, status open.
// - Close-by-current shutdown stops position control, zero output, status open.
// - Close-by-PWM shutdown drives PWM closing, zero output, status open.
// - Shutdown input selects shutdown regardless of every other setting or fault; the code lets the close-by-PWM and close-by-current faults take priority.
// - Fallback on and healthy: loop used if prefer-loop set, else fieldbus.
// - With fallback enabled, a failed source switches demand to the healthy one.
// - Sensors averaged without difference error; otherwise the merge policy decides.
// - Digital positions are 16 bits, 2500 means 0 and 62500 means 100 percent.
// - Merge code 0 selects higher, 1 lower, 2 average.
// - Rising edge of reset-diagnostics bit clears shutdown, alarms and diagnostic bits.
// - Prefer-loop bit set and both healthy selects loop, clear selects fieldbus; the code does this only with fallback enabled, else fieldbus.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "valve_mode_defines.svh"
module valve_demand_mode_selector (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic shutdown_contact_closed,
   input wire logic [15:0] loop_current_ua,
   input wire logic [15:0] sensor_a_pos,
   input wire logic [15:0] sensor_b_pos,
   output var valve_mode_pkg::op_mode_t mode,
   output var valve_mode_pkg::demand_src_t demand_src,
   output logic [15:0] position_setpoint,
   output logic position_control_en,
   output logic current_close_en,
   output logic pwm_close_en,
   output logic [15:0] loop_output_ua,
   output logic status_contact_closed,
   output logic [15:0] merged_position
);
   import valve_mode_pkg::*;

   logic [31:0] ctrl;
   logic [31:0] cfg;
   logic [15:0] fieldbus_demand;
   logic [6:0] faults;
   logic [6:0] fault_set;
   logic reset_diag_prev;
   logic reset_diag_edge;
   logic loop_fault;
   logic shutdown_req;
   logic fallback_en;
   logic prefer_loop_cmd_bit;
   logic fieldbus_loss_fault;
   logic [15:0] feedback_merge_code;
   logic [15:0] loop_demand;
   logic [15:0] higher;
   logic [15:0] lower;
   logic [16:0] pos_sum;
   logic [15:0] next_merged;
   op_mode_t next_mode;
   demand_src_t next_src;
   logic [15:0] next_setpoint;
   logic [15:0] next_out_ua;
   logic aw_hold;
   logic w_hold;
   logic [11:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [31:0] rd_value;
   logic rd_ok;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = data[8*i +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   // Write channel: address and data taken in either order, response after both.
   assign s_axi_awready = !aw_hold && !s_axi_bvalid;
   assign s_axi_wready = !w_hold && !s_axi_bvalid;
   assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;
   assign s_axi_bresp = 2'h0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 12'h000;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software-written registers; unmapped writes are accepted and ignored.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl <= 32'h0000_0000;
         cfg <= `CFG_RESET;
         fieldbus_demand <= `POS_ZERO;
      end else if (wr_fire) begin
         unique case (aw_addr)
            `REG_CTRL: ctrl <= merge_bytes(ctrl, w_data, w_strb);
            `REG_CFG: cfg <= merge_bytes(cfg, w_data, w_strb);
            `REG_DEMAND: fieldbus_demand <= 16'(merge_bytes({16'h0000, fieldbus_demand},
                                                            w_data, w_strb));
            default: ;
         endcase
      end
   end

   // Fault bits: bits 0 to 3 and 5 to 6 are set by writes, bit 4 latches loop faults.
   always_comb begin
      fault_set = 7'h00;
      if (wr_fire && aw_addr == `REG_FAULTS) begin
         fault_set = 7'(w_data) & 7'h6F;
      end
      fault_set[`FLT_DIAG_BIT] = loop_fault;
   end

   assign reset_diag_edge = ctrl[`CTRL_RESET_DIAG_BIT] && !reset_diag_prev;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reset_diag_prev <= 1'b0;
         faults <= 7'h00;
      end else begin
         reset_diag_prev <= ctrl[`CTRL_RESET_DIAG_BIT];
         if (reset_diag_edge) begin
            faults <= fault_set;
         end else begin
            faults <= faults | fault_set;
         end
      end
   end

   assign fallback_en = cfg[`CFG_FALLBACK_BIT];
   assign feedback_merge_code = cfg[`CFG_MERGE_LSB +: 16];
   assign prefer_loop_cmd_bit = ctrl[`CTRL_PREFER_LOOP_BIT];
   assign fieldbus_loss_fault = faults[`FLT_FIELDBUS_BIT] | faults[`FLT_TRACKING_BIT];
   assign shutdown_req = !shutdown_contact_closed || ctrl[`CTRL_SHUTDOWN_BIT];
   assign loop_fault = (loop_current_ua < `LOOP_FAULT_LO_UA) ||
                       (loop_current_ua > `LOOP_FAULT_HI_UA);

   // Loop current scaled onto the digital position span, clamped at the ends.
   always_comb begin
      logic [33:0] prod;
      prod = 34'h0_0000_0000;
      if (loop_current_ua <= `LOOP_LOW_UA) begin
         loop_demand = `POS_ZERO;
      end else if (loop_current_ua >= `LOOP_HIGH_UA) begin
         loop_demand = `POS_FULL;
      end else begin
         prod = 34'(loop_current_ua - `LOOP_LOW_UA) * 34'(`POS_SPAN);
         loop_demand = 16'(prod / 34'(`LOOP_SPAN_UA)) + `POS_ZERO;
      end
   end

   // Sensor merge.
   assign higher = (sensor_a_pos > sensor_b_pos) ? sensor_a_pos : sensor_b_pos;
   assign lower = (sensor_a_pos > sensor_b_pos) ? sensor_b_pos : sensor_a_pos;
   assign pos_sum = {1'b0, sensor_a_pos} + {1'b0, sensor_b_pos};

   always_comb begin
      next_merged = pos_sum[16:1];
      if (faults[`FLT_DIFF1_BIT] || faults[`FLT_DIFF2_BIT]) begin
         if (feedback_merge_code == `MERGE_HIGHER) begin
            next_merged = higher;
         end else if (feedback_merge_code == `MERGE_LOWER) begin
            next_merged = lower;
         end
      end
   end

   // Mode and source decision.
   always_comb begin
      next_src = SRC_NONE;
      if (shutdown_req) begin
         next_src = SRC_NONE;
      end else if (!fallback_en) begin
         next_src = fieldbus_loss_fault ? SRC_NONE : SRC_FIELDBUS;
      end else if (!fieldbus_loss_fault && !faults[`FLT_DIAG_BIT]) begin
         next_src = prefer_loop_cmd_bit ? SRC_LOOP : SRC_FIELDBUS;
      end else if (!fieldbus_loss_fault) begin
         next_src = SRC_FIELDBUS;
      end else if (!faults[`FLT_DIAG_BIT]) begin
         next_src = SRC_LOOP;
      end
      if (faults[`FLT_PWM_BIT]) begin
         next_mode = MODE_SHUTDOWN_SYSTEM;
      end else if (faults[`FLT_CURRENT_BIT]) begin
         next_mode = MODE_SHUTDOWN_POSITION;
      end else if (next_src == SRC_NONE || loop_fault) begin
         next_mode = MODE_SHUTDOWN;
      end else begin
         next_mode = MODE_RUNNING;
      end
      if (next_mode != MODE_RUNNING) begin
         next_setpoint = `POS_ZERO;
      end else begin
         next_setpoint = (next_src == SRC_LOOP) ? loop_demand : fieldbus_demand;
      end
   end

   always_comb begin
      logic [33:0] prod;
      logic [15:0] pos;
      pos = merged_position;
      if (pos < `POS_ZERO) begin
         pos = `POS_ZERO;
      end else if (pos > `POS_FULL) begin
         pos = `POS_FULL;
      end
      prod = 34'(pos - `POS_ZERO) * 34'(`LOOP_SPAN_UA);
      next_out_ua = 16'(prod / 34'(`POS_SPAN)) + `LOOP_LOW_UA;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode <= MODE_SHUTDOWN;
         demand_src <= SRC_NONE;
         position_setpoint <= `POS_ZERO;
         merged_position <= 16'h0000;
      end else begin
         mode <= next_mode;
         demand_src <= next_src;
         position_setpoint <= next_setpoint;
         merged_position <= next_merged;
      end
   end

   // Mode outputs registered from the same decision.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         position_control_en <= 1'b0;
         current_close_en <= 1'b0;
         pwm_close_en <= 1'b0;
         loop_output_ua <= 16'h0000;
         status_contact_closed <= 1'b0;
      end else begin
         position_control_en <= (next_mode == MODE_RUNNING) ||
                                (next_mode == MODE_SHUTDOWN);
         current_close_en <= (next_mode == MODE_SHUTDOWN_POSITION);
         pwm_close_en <= (next_mode == MODE_SHUTDOWN_SYSTEM);
         loop_output_ua <= (next_mode == MODE_RUNNING) ? next_out_ua : 16'h0000;
         status_contact_closed <= (next_mode == MODE_RUNNING);
      end
   end

   // Read channel, one cycle after the address is taken.
   always_comb begin
      rd_ok = 1'b1;
      rd_value = 32'h0000_0000;
      unique case (s_axi_araddr)
         `REG_CTRL: rd_value = ctrl;
         `REG_CFG: rd_value = cfg;
         `REG_DEMAND: rd_value = {16'h0000, fieldbus_demand};
         `REG_LOOP: rd_value = {16'h0000, loop_demand};
         `REG_FAULTS: rd_value = {25'h000_0000, faults};
         `REG_SENSORS: rd_value = {16'h0000, merged_position};
         `REG_STATUS: rd_value = {26'h000_0000, status_contact_closed, pwm_close_en,
                                  demand_src, mode};
         `REG_OUTPUT: rd_value = {16'h0000, loop_output_ua};
         default: rd_ok = 1'b0;
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_value;
         s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   sequence contact_open_s;
      !shutdown_contact_closed;
   endsequence

   shutdown_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
      contact_open_s |=> (mode != MODE_RUNNING) && !status_contact_closed
      && loop_output_ua == 16'h0000 && position_setpoint == `POS_ZERO)
      else $error("shutdown contact open but not shut down");
   zero_out_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode != MODE_RUNNING |-> loop_output_ua == 16'h0000)
      else $error("output current not zero in shutdown");
   status_open_a: assert property (@(posedge clk) disable iff (sys_rst)
      status_contact_closed == (mode == MODE_RUNNING))
      else $error("status contact disagrees with mode");
   loop_fault_a: assert property (@(posedge clk) disable iff (sys_rst)
      loop_fault |=> mode != MODE_RUNNING)
      else $error("loop fault did not shut down");
   pwm_priority_a: assert property (@(posedge clk) disable iff (sys_rst)
      faults[`FLT_PWM_BIT] |=> mode == MODE_SHUTDOWN_SYSTEM && pwm_close_en)
      else $error("pwm close mode not taken");
   current_mode_a: assert property (@(posedge clk) disable iff (sys_rst)
      mode == MODE_SHUTDOWN_POSITION |-> current_close_en && !position_control_en)
      else $error("current close mode outputs wrong");
   prefer_loop_a: assert property (@(posedge clk) disable iff (sys_rst)
      !shutdown_req && fallback_en && prefer_loop_cmd_bit && !fieldbus_loss_fault
      && !faults[`FLT_DIAG_BIT] |=> demand_src == SRC_LOOP)
      else $error("loop demand not selected");
   failover_a: assert property (@(posedge clk) disable iff (sys_rst)
      !shutdown_req && fallback_en && fieldbus_loss_fault && !faults[`FLT_DIAG_BIT]
      |=> demand_src == SRC_LOOP)
      else $error("failover to loop missing");
   diag_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      reset_diag_edge && !loop_fault && !wr_fire |=> faults == 7'h00)
      else $error("diagnostics not cleared");
   resume_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(shutdown_contact_closed) && !ctrl[`CTRL_SHUTDOWN_BIT] && faults == 7'h00
      && !loop_fault && !fallback_en |=> mode == MODE_RUNNING)
      else $error("no resume after contact closed");

endmodule : valve_demand_mode_selector
`default_nettype wire

// File: core/valve_mode_defines.svh
// Register offsets, field positions, reset values and scaling constants of the mode selector.
`ifndef VALVE_MODE_DEFINES_SVH
`define VALVE_MODE_DEFINES_SVH
`define REG_CTRL 12'h000
`define REG_CFG 12'h004
`define REG_DEMAND 12'h008
`define REG_LOOP 12'h00C
`define REG_FAULTS 12'h010
`define REG_SENSORS 12'h014
`define REG_STATUS 12'h018
`define REG_OUTPUT 12'h01C
`define CTRL_SHUTDOWN_BIT 0
`define CTRL_RESET_DIAG_BIT 1
`define CTRL_PREFER_LOOP_BIT 3
`define CFG_FALLBACK_BIT 0
`define CFG_MERGE_LSB 16
`define FLT_FIELDBUS_BIT 0
`define FLT_TRACKING_BIT 1
`define FLT_DIFF1_BIT 2
`define FLT_DIFF2_BIT 3
`define FLT_DIAG_BIT 4
`define FLT_CURRENT_BIT 5
`define FLT_PWM_BIT 6
`define MERGE_HIGHER 16'h0000
`define MERGE_LOWER 16'h0001
`define MERGE_AVERAGE 16'h0002
`define POS_ZERO 16'h09C4
`define POS_FULL 16'hF424
`define POS_SPAN 17'h0EA60
`define LOOP_LOW_UA 16'h0FA0
`define LOOP_HIGH_UA 16'h4E20
`define LOOP_SPAN_UA 17'h03E80
`define LOOP_FAULT_LO_UA 16'h07D0
`define LOOP_FAULT_HI_UA 16'h55F0
`define CFG_RESET 32'h0002_0000
`endif

// File: core/valve_mode_pkg.sv
// Types shared by the valve demand and mode selector.
package valve_mode_pkg;
   typedef enum logic [1:0] {
      MODE_RUNNING,
      MODE_SHUTDOWN,
      MODE_SHUTDOWN_POSITION,
      MODE_SHUTDOWN_SYSTEM
   } op_mode_t;
   typedef enum logic [1:0] {
      SRC_FIELDBUS,
      SRC_LOOP,
      SRC_NONE
   } demand_src_t;
endpackage : valve_mode_pkg
